/* File: core/flash_charger_defines.svh */
`ifndef FLASH_CHARGER_DEFINES_SVH
`define FLASH_CHARGER_DEFINES_SVH

// clock rate in MHz
`define CLK_MHZ 25
// maximum switch off-time in ns (the longer quoted cap is 20000 ns)
`define OFF_TIME_MAX_NS 18000
// longest time rounds down
`define OFF_TIME_MAX_CYC ((`OFF_TIME_MAX_NS * `CLK_MHZ) / 1000)
// limit setup window in ns, least time rounds up
`define SETUP_WINDOW_NS 54000
`define SETUP_WINDOW_CYC ((`SETUP_WINDOW_NS * `CLK_MHZ + 999) / 1000)
// host first pulse high time in ns
`define FIRST_PULSE_NS 20000
`define FIRST_PULSE_CYC ((`FIRST_PULSE_NS * `CLK_MHZ + 999) / 1000)
// host later pulse width in ns, no less than one cycle
`define LATER_PULSE_NS 200
`define LATER_PULSE_CYC 1
// host gap between burst edges, in cycles
`define BURST_GAP_CYC 4
// most edges counted in a burst
`define MAX_EDGES 8

`endif

/* File: core/flash_charger_pkg.sv */
package flash_charger_pkg;

  // charger states, gray coded along idle-setup-on-off
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_setup = 3'h1,
    st_on = 3'h3,
    st_off = 3'h2,
    st_done = 3'h6
  } charger_state_type;

  // host states
  typedef enum logic [2:0] {
    hs_low = 3'h0,
    hs_high = 3'h1,
    hs_gap = 3'h3,
    hs_hold = 3'h2
  } host_state_type;

endpackage

/* File: core/charge_link_if.sv */
`timescale 1ns/1ps
interface charge_link_if;
  logic charge_cmd;

  modport device (input charge_cmd);
  modport host (output charge_cmd);
endinterface

/* File: core/input_sync.sv */
`timescale 1ns/1ps
// four flops, a change counts once stages two and three agree
module input_sync (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2, so no logic sees a metastable value
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule // input_sync

/* File: core/flash_charger_control.sv */
// Operation
// - rising command starts charge above lockout
// - command high at lockout release needs fresh edge
// - overcurrent turns switch off at once
// - next cycle on flux reset or off-timeout
// - flux reset from low switch-node sense
// - feedback reaching target stops switching
// - ten percent droop restarts charge automatically
// - command low-high toggle starts refresh charge
// - up to eight edges choose limit
// - first edge starts the edge counter
// - host holds first pulse twenty microseconds
// - host sends up to seven short pulses
// - host ends burst within window, stays high
// - switching waits for setup window end
// - limit kept while command stays high
// - low command outside the setup window clears the edge counter
`timescale 1ns/1ps
`include "flash_charger_defines.svh"
module flash_charger_control #(
  parameter int OFF_MAX_CYC = `OFF_TIME_MAX_CYC,
  parameter int SETUP_CYC = `SETUP_WINDOW_CYC,
  // one 3-bit code per count 1..8, count 1 in the low bits
  parameter logic [23:0] LIMIT_TABLE = 24'hfac688
) (
  input wire logic sys_clk,
  input wire logic rstn,
  charge_link_if.device link,
  input wire logic supply_ok,
  input wire logic overcurrent,
  input wire logic flux_reset,
  input wire logic output_feedback_sense,
  input wire logic refresh_low,
  output logic switch_on,
  output logic [2:0] switch_peak_current_limit,
  output logic charging,
  output logic charge_done
);
  logic cmd;
  logic cmd_prev;
  logic oc;
  logic flux;
  logic fb;
  logic droop;
  logic uv_ok;
  logic armed;
  logic [3:0] edge_count;
  logic [15:0] timer;
  flash_charger_pkg::charger_state_type state;
  flash_charger_pkg::charger_state_type next_state;

  input_sync sync_cmd (.sys_clk(sys_clk), .rstn(rstn), .async_in(link.charge_cmd),
    .sync_out(cmd));
  input_sync sync_uv (.sys_clk(sys_clk), .rstn(rstn), .async_in(supply_ok), .sync_out(uv_ok));
  input_sync sync_oc (.sys_clk(sys_clk), .rstn(rstn), .async_in(overcurrent), .sync_out(oc));
  input_sync sync_fl (.sys_clk(sys_clk), .rstn(rstn), .async_in(flux_reset), .sync_out(flux));
  input_sync sync_fb (.sys_clk(sys_clk), .rstn(rstn), .async_in(output_feedback_sense),
    .sync_out(fb));
  input_sync sync_dr (.sys_clk(sys_clk), .rstn(rstn), .async_in(refresh_low), .sync_out(droop));

  // state decode
  wire in_idle = (state == flash_charger_pkg::st_idle);
  wire in_setup = (state == flash_charger_pkg::st_setup);
  wire in_on = (state == flash_charger_pkg::st_on);
  wire timer_end = (timer == 16'h0000);
  // burst gaps are lows inside the window; they must not abort or clear the count
  wire in_window = in_setup & ~timer_end;
  wire window_end = in_setup & timer_end;

  // command edge and start qualification
  wire rise = cmd & ~cmd_prev;
  // a start needs armed: a low seen while supply was good; later burst edges are no start
  wire start = in_idle & rise & uv_ok & armed;
  // a low outside the window, or supply loss, ends any charge
  wire abort = ~uv_ok | (~cmd & ~in_window);
  wire count_clear = ~cmd & ~in_window;
  wire count_first = rise & (edge_count == 4'h0);
  wire count_more = rise & in_setup & (edge_count < 4'(`MAX_EDGES));

  // limit lookup; the count is never zero once a window has begun
  wire [2:0] count_idx = 3'(edge_count - 4'h1);
  wire [2:0] limit_code = LIMIT_TABLE[3 * count_idx +: 3];

  // timer reload values, cut to the counter width on purpose
  wire [15:0] setup_load = 16'(SETUP_CYC - 1);
  wire [15:0] off_load = 16'(OFF_MAX_CYC - 2);

  // switching decode from the next state, so outputs move on the deciding edge
  wire going_off = in_on & (next_state == flash_charger_pkg::st_off);
  wire next_on = (next_state == flash_charger_pkg::st_on);
  wire next_done = (next_state == flash_charger_pkg::st_done);
  wire next_busy = (next_state != flash_charger_pkg::st_idle) & ~next_done;

  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      flash_charger_pkg::st_idle: begin
        if (start) begin
          next_state = flash_charger_pkg::st_setup;
        end
      end
      flash_charger_pkg::st_setup: begin
        if (timer_end) begin
          next_state = flash_charger_pkg::st_on;
        end
      end
      flash_charger_pkg::st_on: begin
        if (fb) begin
          next_state = flash_charger_pkg::st_done;
        end else if (oc) begin
          next_state = flash_charger_pkg::st_off;
        end
      end
      flash_charger_pkg::st_off: begin
        if (fb) begin
          next_state = flash_charger_pkg::st_done;
        end else if (flux || timer_end) begin
          next_state = flash_charger_pkg::st_on;
        end
      end
      flash_charger_pkg::st_done: begin
        if (droop) begin
          next_state = flash_charger_pkg::st_on;
        end
      end
      default: next_state = flash_charger_pkg::st_idle;
    endcase
    if (abort) begin
      next_state = flash_charger_pkg::st_idle;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= flash_charger_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // previous command level; resets to the idle low level so no false edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_prev <= 1'b0;
    end else begin
      cmd_prev <= cmd;
    end
  end

  // high command at supply release leaves the block unarmed
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (!uv_ok) begin
      armed <= 1'b0;
    end else if (!cmd) begin
      armed <= 1'b1;
    end
  end

  // one down-counter serves both the setup window and the off-time cap
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timer <= 16'h0000;
    end else if (start) begin
      timer <= setup_load;
    end else if (going_off) begin
      timer <= off_load;
    end else if (!timer_end) begin
      timer <= timer - 16'h0001;
    end
  end

  // edge counter: cleared by a low outside the window, takes the first edge whenever the count is zero, later edges only in setup
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      edge_count <= 4'h0;
    end else if (count_clear) begin
      edge_count <= 4'h0;
    end else if (count_first) begin
      edge_count <= 4'h1;
    end else if (count_more) begin
      edge_count <= edge_count + 4'h1;
    end
  end

  // switch gate
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      switch_on <= 1'b0;
    end else begin
      switch_on <= next_on;
    end
  end

  // limit latched at window end and held while the command stays high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      switch_peak_current_limit <= 3'h0;
    end else if (window_end) begin
      switch_peak_current_limit <= limit_code;
    end
  end

  // status levels
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      charging <= 1'b0;
      charge_done <= 1'b0;
    end else begin
      charging <= next_busy;
      charge_done <= next_done;
    end
  end
endmodule // flash_charger_control

/* File: core/flash_charger_host.sv */
`timescale 1ns/1ps
`include "flash_charger_defines.svh"
module flash_charger_host #(
  parameter int FIRST_CYC = `FIRST_PULSE_CYC,
  parameter int GAP_CYC = `BURST_GAP_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  charge_link_if.host link,
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] pulses_extra,
  output logic busy
);
  flash_charger_pkg::host_state_type state;
  logic [15:0] timer;
  logic [2:0] left;
  logic pin;

  assign link.charge_cmd = pin;
  wire timer_end = (timer == 16'h0000);

  // burst: long first pulse, then short pulses, then hold high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= flash_charger_pkg::hs_low;
      timer <= 16'h0000;
      left <= 3'h0;
      pin <= 1'b0;
      busy <= 1'b0;
    end else if (stop) begin
      state <= flash_charger_pkg::hs_low;
      pin <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (!timer_end) begin
        timer <= timer - 16'h0001;
      end
      case (state)
        flash_charger_pkg::hs_low: begin
          // pin was low at least one cycle before a new burst
          if (start && !pin) begin
            pin <= 1'b1;
            busy <= 1'b1;
            left <= pulses_extra;
            timer <= 16'(FIRST_CYC);
            state <= flash_charger_pkg::hs_high;
          end else begin
            pin <= 1'b0;
          end
        end
        flash_charger_pkg::hs_high: begin
          if (timer_end) begin
            if (left == 3'h0) begin
              state <= flash_charger_pkg::hs_hold;
              busy <= 1'b0;
            end else begin
              pin <= 1'b0;
              timer <= 16'(GAP_CYC);
              state <= flash_charger_pkg::hs_gap;
            end
          end
        end
        flash_charger_pkg::hs_gap: begin
          if (timer_end) begin
            pin <= 1'b1;
            left <= left - 3'h1;
            timer <= 16'(GAP_CYC);
            state <= flash_charger_pkg::hs_high;
          end
        end
        flash_charger_pkg::hs_hold: begin
          pin <= 1'b1;
        end
        default: state <= flash_charger_pkg::hs_low;
      endcase
    end
  end
endmodule // flash_charger_host

/* File: sim/flash_charger_asserts.sv */
`timescale 1ns/1ps
module flash_charger_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic charge_cmd,
  input wire logic busy,
  input wire logic switch_on,
  input wire logic charging,
  input wire logic charge_done,
  input wire logic overcurrent,
  input wire logic output_feedback_sense,
  input wire logic [2:0] switch_peak_current_limit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // inputs pass a synchronizer, so six cycles of slack
  cmd_low_off_a: assert property (!charge_cmd [*6] |-> !switch_on)
    else $error("switch on with command low");
  oc_off_a: assert property (overcurrent [*6] |-> !switch_on)
    else $error("switch on during overcurrent");
  target_stop_a: assert property (output_feedback_sense [*6] |-> !switch_on)
    else $error("switch on at target");
  done_quiet_a: assert property (charge_done |-> !switch_on && !charging)
    else $error("switching while done");
  start_cmd_a: assert property ($rose(charging) |-> charge_cmd)
    else $error("charge start without command");
  setup_hold_a: assert property ($rose(charging) && busy |-> !switch_on [*8])
    else $error("switch on inside setup window");
  limit_kept_a: assert property (switch_on && $past(switch_on)
    |-> $stable(switch_peak_current_limit))
    else $error("limit changed while switching");
  first_pulse_a: assert property ($rose(busy) |-> charge_cmd [*8])
    else $error("first pulse too short");
  burst_end_a: assert property ($fell(busy) |-> charge_cmd [*8])
    else $error("command not held after burst");
  cover property ($rose(switch_on));
  cover property ($rose(charge_done));
  cover property ($fell(busy));
endmodule // flash_charger_asserts

/* File: sim/flash_charger_control_tb_top.sv */
`timescale 1ns/1ps
module flash_charger_control_tb_top;
  // short counts keep the run brief; the window must outlast the longest burst
  localparam int OFF = 20;
  localparam int SETUP = 60;
  localparam int FIRST = 10;
  localparam int GAP = 2;
  localparam logic [23:0] TABLE = 24'hfac688;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_ok = 1'b0, overcurrent = 1'b0, flux_reset = 1'b0;
  logic fb = 1'b0, refresh_low = 1'b0, start = 1'b0, stop = 1'b0;
  logic [2:0] pulses_extra = 3'h0;
  logic switch_on, charging, charge_done, busy;
  logic [2:0] limit;
  int err_total = 0;
  int compares = 0;
  int n, m;
  charge_link_if link ();
  flash_charger_control #(.OFF_MAX_CYC(OFF), .SETUP_CYC(SETUP), .LIMIT_TABLE(TABLE))
    flash_charger_control_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link.device),
    .supply_ok(supply_ok), .overcurrent(overcurrent), .flux_reset(flux_reset),
    .output_feedback_sense(fb), .refresh_low(refresh_low), .switch_on(switch_on),
    .switch_peak_current_limit(limit), .charging(charging), .charge_done(charge_done));
  flash_charger_host #(.FIRST_CYC(FIRST), .GAP_CYC(GAP)) flash_charger_host_inst (
    .sys_clk(sys_clk), .rstn(rstn), .link(link.host), .start(start), .stop(stop),
    .pulses_extra(pulses_extra), .busy(busy));
  flash_charger_asserts flash_charger_asserts_inst (.sys_clk(sys_clk), .rstn(rstn),
    .charge_cmd(link.charge_cmd), .busy(busy), .switch_on(switch_on),
    .charging(charging), .charge_done(charge_done), .overcurrent(overcurrent),
    .output_feedback_sense(fb), .switch_peak_current_limit(limit));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // a burst, counting cycles until the host lets go
  task automatic burst(input logic [2:0] k, output int c);
    pulses_extra = k;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    c = 1;
    while (busy !== 1'b0 && c < 200) begin
      cyc(1);
      c++;
    end
  endtask
  // bounded wait so a dead switch cannot hang the run
  task automatic wait_sw(input logic v, output int c);
    c = 0;
    while (switch_on !== v && c < 200) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic drop();
    stop = 1'b1;
    cyc(6);
    stop = 1'b0;
    chk("drop_sw", {1'b0, switch_on, charging}, 3'h0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
  initial begin
    cyc(8);
    rstn = 1'b1;
    cyc(1);
    // command already high when lockout clears
    burst(3'h0, m);
    supply_ok = 1'b1;
    cyc(20);
    chk("stale_cmd", {2'b0, charging}, 3'h0);
    drop();
    for (int k = 0; k < 8; k++) begin
      burst(k[2:0], m);
      chk("burst", {2'b0, m == FIRST + 2 + k * (2 * GAP + 2)}, 3'h1);
      wait_sw(1'b1, n);
      chk("setup", {1'b0, m + n >= SETUP, m + n < SETUP + 12}, 3'h3);
      chk("limit", limit, TABLE[3*k+:3]);
      overcurrent = 1'b1;
      cyc(8);
      overcurrent = 1'b0;
      flux_reset = k[0];
      wait_sw(1'b1, n);
      chk("off_time", {2'b0, n < OFF - 8}, {2'b0, k[0]});
      flux_reset = 1'b0;
      chk("limit_kept", limit, TABLE[3*k+:3]);
      if (k == 3) begin
        fb = 1'b1;
        cyc(8);
        chk("done", {1'b0, charge_done, charging}, 3'h2);
        fb = 1'b0;
        refresh_low = 1'b1;
        cyc(8);
        chk("refresh", {2'b0, charging}, 3'h1);
        refresh_low = 1'b0;
      end
      drop();
    end
    test_done();
  end
endmodule // flash_charger_control_tb_top
